/* inc/ttws_pkg.sv */
// Constants and types for the test, trap, wait and swap unit
package ttws_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 20;
    localparam int FLAG_W = 8;
    // Flag register bit positions
    localparam int FLG_CARRY = 0;
    localparam int FLG_DEBUG = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_SIGN = 3;
    localparam int FLG_BANK = 4;
    localparam int FLG_OVF = 5;
    localparam int FLG_IEN = 6;
    localparam int FLG_STK = 7;
    // Reset values and constants
    localparam logic [ADDR_W-1:0] TRAP_VECTOR = 20'hfffdc;
    localparam logic [DATA_W-1:0] SP_STEP = 16'h0002;
    localparam logic [FLAG_W-1:0] FLG_RESET = 8'h00;
    localparam logic [2:0] IPL_RESET = 3'h0;
    localparam logic [DATA_W-1:0] SP_RESET = 16'h0000;
    // Operation codes on the issue port
    typedef enum logic [2:0] {
        TTWS_OP_NONE = 3'h0,
        TTWS_OP_TEST = 3'h1,
        TTWS_OP_SWAP = 3'h2,
        TTWS_OP_TRAP = 3'h3,
        TTWS_OP_WAIT = 3'h4
    } ttws_op_t;
endpackage

/* core/ttws_operand.sv */
// Operand sizing: byte zero-extension and address-register narrowing
`timescale 1ns/10ps
`default_nettype none
module ttws_operand
    import ttws_pkg::*;
(
    input wire logic byteSize,
    input wire logic srcIsAddr,
    input wire logic dstIsAddr,
    input wire logic [DATA_W-1:0] srcVal,
    input wire logic [DATA_W-1:0] dstVal,
    output logic [DATA_W-1:0] srcOp,
    output logic [DATA_W-1:0] dstOp,
    output logic [DATA_W-1:0] andRes,
    output logic signBit,
    output logic zeroBit
);
    wire logic [DATA_W-1:0] srcLow = {{(DATA_W-BYTE_W){1'b0}}, srcVal[BYTE_W-1:0]};
    wire logic [DATA_W-1:0] dstLow = {{(DATA_W-BYTE_W){1'b0}}, dstVal[BYTE_W-1:0]};
    // Byte width unless destination is an address register and source is not
    wire logic narrow = byteSize && (srcIsAddr || !dstIsAddr);
    assign srcOp = byteSize ? srcLow : srcVal;
    // Byte destination keeps 16 bits only for an address register with a non-address source
    assign dstOp = narrow ? dstLow : dstVal;
    assign andRes = srcOp & dstOp;
    assign signBit = narrow ? andRes[BYTE_W-1] : andRes[DATA_W-1];
    assign zeroBit = (andRes == '0);
endmodule // ttws_operand
`default_nettype wire

/* core/ttws_unit.sv */
// Test, trap, wait and swap execution unit
// Function
// - Test ANDs operands, flags only, no writes
// - Sign from MSB, zero for zero result
// - Byte to address register: zero-extend source
// - Byte from address register: low eight bits
// - Trap pushes PC and flags, then vectors
// - Trap ignores interrupt enable and priority
// - Push old flags, then clear three flags
// - Wait halts fetch and execution
// - Resume on higher interrupt or reset
// - Swap exchanges source and destination
// - Byte swap to address register: zero-extend
`timescale 1ns/10ps
`default_nettype none
module ttws_unit
    import ttws_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic issueValid,
    input wire ttws_op_t issueOp,
    input wire logic byteSize,
    input wire logic srcIsAddr,
    input wire logic dstIsAddr,
    input wire logic [DATA_W-1:0] srcVal,
    input wire logic [DATA_W-1:0] dstVal,
    input wire logic [ADDR_W-1:0] pcNow,
    input wire logic [FLAG_W-1:0] flagIn,
    input wire logic [2:0] iplIn,
    input wire logic [DATA_W-1:0] spIn,
    input wire logic [ADDR_W-1:0] trapTarget,
    input wire logic irqReq,
    input wire logic [2:0] irqLevel,
    output logic [FLAG_W-1:0] flagOut,
    output logic flagWe,
    output logic [DATA_W-1:0] srcWrVal,
    output logic srcWe,
    output logic [DATA_W-1:0] dstWrVal,
    output logic dstWe,
    output logic [DATA_W-1:0] spOut,
    output logic spWe,
    output logic [ADDR_W-1:0] memAddr,
    output logic [DATA_W-1:0] memWrData,
    output logic memWe,
    output logic [ADDR_W-1:0] vecAddr,
    output logic vecRd,
    output logic [ADDR_W-1:0] pcOut,
    output logic pcWe,
    output logic halted,
    output logic irqAck,
    output logic busy
);
    typedef enum logic [2:0] {
        TTWS_IDLE, TTWS_PUSH_HI, TTWS_PUSH_LO, TTWS_VECTOR, TTWS_LOAD_PC, TTWS_HALT
    } ttws_state_t;

    ttws_state_t state_q, state_d;
    logic [ADDR_W-1:0] retPc_q;
    logic [FLAG_W-1:0] oldFlg_q;
    logic [DATA_W-1:0] sp_q;

    logic [DATA_W-1:0] srcOp, dstOp, andRes;
    logic signBit, zeroBit;

    ttws_operand u_operand (
        .byteSize(byteSize),
        .srcIsAddr(srcIsAddr),
        .dstIsAddr(dstIsAddr),
        .srcVal(srcVal),
        .dstVal(dstVal),
        .srcOp(srcOp),
        .dstOp(dstOp),
        .andRes(andRes),
        .signBit(signBit),
        .zeroBit(zeroBit)
    );

    wire logic idle = (state_q == TTWS_IDLE);
    wire logic doTest = idle && issueValid && (issueOp == TTWS_OP_TEST);
    wire logic doSwap = idle && issueValid && (issueOp == TTWS_OP_SWAP);
    wire logic doTrap = idle && issueValid && (issueOp == TTWS_OP_TRAP);
    wire logic doWait = idle && issueValid && (issueOp == TTWS_OP_WAIT);
    wire logic wake = (state_q == TTWS_HALT) && irqReq && (irqLevel > iplIn);
    wire logic [DATA_W-1:0] spDec = sp_q - SP_STEP;
    wire logic [ADDR_W-1:0] retNext = pcNow + 20'h00001;

    wire logic [FLAG_W-1:0] testFlags = (flagIn & ~(8'h01 << FLG_SIGN) & ~(8'h01 << FLG_ZERO))
        | ({7'h00, signBit} << FLG_SIGN) | ({7'h00, zeroBit} << FLG_ZERO);
    wire logic [FLAG_W-1:0] trapFlags = oldFlg_q & ~(8'h01 << FLG_STK) & ~(8'h01 << FLG_IEN)
        & ~(8'h01 << FLG_DEBUG);
    wire logic [DATA_W-1:0] swapToDst = byteSize ? srcOp : srcVal;
    wire logic [DATA_W-1:0] swapToSrc = byteSize ? {8'h00, dstVal[BYTE_W-1:0]} : dstVal;

    always_comb begin
        state_d = state_q;
        case (state_q)
            TTWS_IDLE: begin
                if (doTrap) begin
                    state_d = TTWS_PUSH_HI;
                end else if (doWait) begin
                    state_d = TTWS_HALT;
                end
            end
            TTWS_PUSH_HI: state_d = TTWS_PUSH_LO;
            TTWS_PUSH_LO: state_d = TTWS_VECTOR;
            TTWS_VECTOR: state_d = TTWS_LOAD_PC;
            TTWS_LOAD_PC: state_d = TTWS_IDLE;
            TTWS_HALT: begin
                if (wake) begin
                    state_d = TTWS_IDLE;
                end
            end
            default: state_d = TTWS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            state_q <= TTWS_IDLE;
            retPc_q <= '0;
            oldFlg_q <= FLG_RESET;
            sp_q <= SP_RESET;
            flagOut <= FLG_RESET;
            flagWe <= 1'b0;
            srcWrVal <= '0;
            srcWe <= 1'b0;
            dstWrVal <= '0;
            dstWe <= 1'b0;
            spOut <= SP_RESET;
            spWe <= 1'b0;
            memAddr <= '0;
            memWrData <= '0;
            memWe <= 1'b0;
            vecAddr <= '0;
            vecRd <= 1'b0;
            pcOut <= '0;
            pcWe <= 1'b0;
            halted <= 1'b0;
            irqAck <= 1'b0;
            busy <= 1'b0;
        end else begin
            state_q <= state_d;
            flagWe <= 1'b0;
            srcWe <= 1'b0;
            dstWe <= 1'b0;
            spWe <= 1'b0;
            memWe <= 1'b0;
            vecRd <= 1'b0;
            pcWe <= 1'b0;
            irqAck <= 1'b0;
            busy <= (state_d != TTWS_IDLE) && (state_d != TTWS_HALT);
            halted <= (state_d == TTWS_HALT);
            if (doTest) begin
                flagOut <= testFlags;
                flagWe <= 1'b1;
            end
            if (doSwap) begin
                dstWrVal <= swapToDst;
                srcWrVal <= swapToSrc;
                dstWe <= 1'b1;
                srcWe <= 1'b1;
            end
            if (doTrap) begin
                retPc_q <= retNext;
                oldFlg_q <= flagIn;
                sp_q <= spIn;
            end
            case (state_q)
                TTWS_PUSH_HI: begin
                    sp_q <= spDec;
                    memAddr <= {4'h0, spDec};
                    memWrData <= {4'h0, retPc_q[ADDR_W-1:DATA_W], oldFlg_q};
                    memWe <= 1'b1;
                end
                TTWS_PUSH_LO: begin
                    sp_q <= spDec;
                    memAddr <= {4'h0, spDec};
                    memWrData <= retPc_q[DATA_W-1:0];
                    memWe <= 1'b1;
                    spOut <= spDec;
                    spWe <= 1'b1;
                    flagOut <= trapFlags;
                    flagWe <= 1'b1;
                    vecAddr <= TRAP_VECTOR;
                    vecRd <= 1'b1;
                end
                TTWS_LOAD_PC: begin
                    pcOut <= trapTarget;
                    pcWe <= 1'b1;
                end
                TTWS_HALT: begin
                    irqAck <= wake;
                end
                default: begin
                end
            endcase
        end
    end
endmodule // ttws_unit
`default_nettype wire

/* tb/ttws_props.sv */
// Checker for the test, trap, wait and swap unit
`timescale 1ns/10ps
`default_nettype none
module ttws_props
    import ttws_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic issueValid,
    input wire ttws_op_t issueOp,
    input wire logic byteSize,
    input wire logic dstIsAddr,
    input wire logic [DATA_W-1:0] srcVal,
    input wire logic [DATA_W-1:0] dstVal,
    input wire logic [FLAG_W-1:0] flagIn,
    input wire logic [2:0] iplIn,
    input wire logic [DATA_W-1:0] spIn,
    input wire logic [ADDR_W-1:0] trapTarget,
    input wire logic irqReq,
    input wire logic [2:0] irqLevel,
    input wire logic [FLAG_W-1:0] flagOut,
    input wire logic flagWe,
    input wire logic [DATA_W-1:0] srcWrVal,
    input wire logic srcWe,
    input wire logic [DATA_W-1:0] dstWrVal,
    input wire logic dstWe,
    input wire logic [DATA_W-1:0] spOut,
    input wire logic spWe,
    input wire logic [DATA_W-1:0] memWrData,
    input wire logic memWe,
    input wire logic [ADDR_W-1:0] pcOut,
    input wire logic pcWe,
    input wire logic halted,
    input wire logic irqAck,
    input wire logic busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire go = issueValid && !busy && !halted;
    wire wake = irqReq && (irqLevel > iplIn);
    test_flags_a: assert property (go && issueOp == TTWS_OP_TEST |=> flagWe && !dstWe
        && (flagOut & 8'hf3) == ($past(flagIn) & 8'hf3)) else $error("test flags wrong");
    swap_word_a: assert property (go && issueOp == TTWS_OP_SWAP && !byteSize |=> srcWe
        && dstWe && !flagWe && srcWrVal == $past(dstVal) && dstWrVal == $past(srcVal))
        else $error("word swap wrong");
    swap_byte_a: assert property (go && issueOp == TTWS_OP_SWAP && byteSize && dstIsAddr
        |=> dstWrVal == {8'h00, $past(srcVal[7:0])} && srcWrVal[7:0] == $past(dstVal[7:0]))
        else $error("byte swap wrong");
    trap_seq_a: assert property (go && issueOp == TTWS_OP_TRAP |=> busy [*4] ##1
        (!busy && pcWe && pcOut == $past(trapTarget))) else $error("trap sequence wrong");
    trap_push_a: assert property (go && issueOp == TTWS_OP_TRAP |-> ##2
        (memWe && memWrData[7:0] == $past(flagIn, 2)) ##1
        (memWe && spWe && spOut == $past(spIn, 3) - 16'h0004)) else $error("trap push wrong");
    trap_flags_a: assert property (go && issueOp == TTWS_OP_TRAP |-> ##3 flagWe
        && flagOut == ($past(flagIn, 3) & 8'h3d)) else $error("trap flags wrong");
    wait_halt_a: assert property (go && issueOp == TTWS_OP_WAIT |=> halted && !flagWe)
        else $error("wait did not halt");
    wake_up_a: assert property (halted && wake |=> irqAck && !halted)
        else $error("no wake on interrupt");
    stay_halted_a: assert property (halted && !wake |=> halted && !flagWe && !memWe)
        else $error("left halt early");
    cover property (go && issueOp == TTWS_OP_TRAP);
    cover property (halted && wake);
    cover property (go && issueOp == TTWS_OP_SWAP && byteSize);
endmodule // ttws_props
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the test, trap, wait and swap unit
`timescale 1ns/10ps
`default_nettype none
module tb
    import ttws_pkg::*;
;
    logic core_clk = 1'b0, resetn = 1'b0, issueValid = 1'b0, byteSize = 1'b0;
    logic srcIsAddr = 1'b0, dstIsAddr = 1'b0, irqReq = 1'b0;
    ttws_op_t issueOp = TTWS_OP_NONE;
    logic [DATA_W-1:0] srcVal = '0, dstVal = '0, spIn = 16'h0100;
    logic [ADDR_W-1:0] pcNow = 20'h5ffff, trapTarget = 20'h34567;
    logic [FLAG_W-1:0] flagIn = '0;
    logic [2:0] iplIn = 3'h3, irqLevel = 3'h0;
    logic [FLAG_W-1:0] flagOut;
    logic [DATA_W-1:0] srcWrVal, dstWrVal, spOut, memWrData;
    logic [ADDR_W-1:0] memAddr, vecAddr, pcOut;
    logic flagWe, srcWe, dstWe, spWe, memWe, vecRd, pcWe, halted, irqAck, busy;
    wire [4:0] strobes = {irqAck, pcWe, memWe, dstWe, flagWe};
    int miscompares = 0, n_tests = 0;
    ttws_unit uut (.core_clk, .resetn, .issueValid, .issueOp, .byteSize, .srcIsAddr,
        .dstIsAddr, .srcVal, .dstVal, .pcNow, .flagIn, .iplIn, .spIn, .trapTarget, .irqReq,
        .irqLevel, .flagOut, .flagWe, .srcWrVal, .srcWe, .dstWrVal, .dstWe, .spOut, .spWe,
        .memAddr, .memWrData, .memWe, .vecAddr, .vecRd, .pcOut, .pcWe, .halted, .irqAck, .busy);
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic conclude();
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic waitOn(input int b);
        int i;
        for (i = 0; i < 20 && strobes[b] !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        if (i == 20) begin
            miscompares++;
            conclude();
        end
    endtask
    task automatic issue(input ttws_op_t op, input logic bs, sa, da,
        input logic [15:0] s, d, input logic [7:0] f);
        @(negedge core_clk);
        issueOp = op;
        byteSize = bs;
        srcIsAddr = sa;
        dstIsAddr = da;
        srcVal = s;
        dstVal = d;
        flagIn = f;
        issueValid = 1'b1;
        @(negedge core_clk);
        issueValid = 1'b0;
    endtask
    task automatic chkTest(input logic bs, sa, da, input logic [15:0] s, d,
        input logic [7:0] f, e);
        issue(TTWS_OP_TEST, bs, sa, da, s, d, f);
        waitOn(0);
        cmp(flagOut, e);
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        resetn = 1'b1;
        chkTest(0, 0, 0, 16'h8000, 16'hffff, 8'hf3, 8'hfb);
        chkTest(0, 0, 0, 16'h00f0, 16'h0f00, 8'h0c, 8'h04);
        chkTest(1, 0, 1, 16'hff80, 16'h8000, 8'h00, 8'h04);
        chkTest(1, 1, 0, 16'h12ff, 16'h80ff, 8'h00, 8'h08);
        chkTest(1, 0, 0, 16'h0080, 16'h1280, 8'h00, 8'h08);
        issue(TTWS_OP_SWAP, 0, 0, 0, 16'h1234, 16'habcd, 8'h00);
        waitOn(1);
        cmp(dstWrVal, 16'h1234);
        cmp(srcWrVal, 16'habcd);
        issue(TTWS_OP_SWAP, 1, 0, 1, 16'hff5a, 16'h9c3e, 8'h00);
        waitOn(1);
        cmp(dstWrVal, 16'h005a);
        cmp(srcWrVal[7:0], 8'h3e);
        issue(TTWS_OP_TRAP, 0, 0, 0, 16'h0000, 16'h0000, 8'hff);
        waitOn(2);
        cmp(memAddr[15:0], 16'h00fe);
        cmp(memWrData, 16'h06ff);
        @(negedge core_clk);
        cmp(memAddr[15:0], 16'h00fc);
        cmp(memWrData, 16'h0000);
        cmp(spOut, 16'h00fc);
        cmp(flagOut, 8'h3d);
        cmp(vecAddr, 20'hfffdc);
        cmp(vecRd, 1'b1);
        waitOn(3);
        cmp(pcOut, trapTarget);
        issue(TTWS_OP_WAIT, 0, 0, 0, 16'h0000, 16'h0000, 8'h00);
        cmp(halted, 1'b1);
        irqReq = 1'b1;
        irqLevel = 3'h3;
        // Ignored while halted
        issue(TTWS_OP_TEST, 0, 0, 0, 16'h0000, 16'h0000, 8'h00);
        repeat (3) @(negedge core_clk);
        cmp(halted, 1'b1);
        irqLevel = 3'h4;
        waitOn(4);
        cmp(halted, 1'b0);
        irqReq = 1'b0;
        conclude();
    end
endmodule // tb
bind ttws_unit ttws_props chk (.core_clk, .resetn, .issueValid, .issueOp, .byteSize,
    .dstIsAddr, .srcVal, .dstVal, .flagIn, .iplIn, .spIn, .trapTarget, .irqReq, .irqLevel,
    .flagOut, .flagWe, .srcWrVal, .srcWe, .dstWrVal, .dstWe, .spOut, .spWe, .memWrData,
    .memWe, .pcOut, .pcWe, .halted, .irqAck, .busy);
`default_nettype wire
